/* hdl/usdp_data_port.sv */
// usdp_data_port: uart shadow receive/transmit data port behind apb
// How it works
// - sixteen word aliases all reach one data path
// - read returns char from serial or infrared
// - no fifo: new char overwrites, flags overrun
// - fifo mode: read returns receive fifo head
// - full receive fifo drops new char, overrun
// - written char goes to serial or infrared
// - no fifo: one write clears holding empty
// - no fifo: extra writes overwrite pending char
// - fifo mode: sixteen in the fifo plus one in the output stage before full
// - write to full transmit fifo is dropped
`timescale 1ns/1ps
module usdp_data_port
   import usdp_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_sys_rst,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [31:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // received characters from the deserialisers
   input  wire logic        i_rx_uart_valid,
   input  wire logic [7:0]  i_rx_uart_char,
   input  wire logic        i_rx_ir_valid,
   input  wire logic [7:0]  i_rx_ir_char,
   // characters to the serialisers
   output logic             o_tx_uart_valid,
   output logic             o_tx_ir_valid,
   output logic [7:0]       o_tx_char,
   output logic [7:0]       o_tx_ir_char_n,
   input  wire logic        i_tx_ready,
   // flags toward the rest of the uart
   output logic             o_rx_data_ready,
   output logic             o_tx_holding_empty,
   output logic             o_overrun,
   output logic             o_fifo_enable,
   output logic             o_ir_mode
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      usdp_apb_phase_t phase;
      logic            fifo_en;
      logic            ir_mode;
      logic [31:0]     rdata;
      logic            rd_had;    // captured read saw a valid char
      logic [7:0]      rx_buffer;
      logic            rx_full;
      logic            overrun;
      logic [7:0]      tx_holding;
      logic            tx_full;
      logic [7:0]      tx_char;
      logic            tx_valid;
   } usdp_state_t;

   usdp_state_t st;
   usdp_state_t next_st;

   // address decode shared by capture and completion
   function automatic logic usdp_is_alias(input logic [31:0] a);
      return (a >= USDP_ALIAS_BASE) && (a <= USDP_ALIAS_LAST) && (a[1:0] == 2'b00);
   endfunction : usdp_is_alias

   function automatic logic usdp_is_mapped(input logic [31:0] a);
      return usdp_is_alias(a) || (a == USDP_CTRL_ADDR) || (a == USDP_STAT_ADDR);
   endfunction : usdp_is_mapped

   // ---------------------------------------------------------------
   // fifo wiring
   // ---------------------------------------------------------------
   logic       rxf_wr_valid;
   logic       rxf_wr_ready;
   logic       rxf_rd_valid;
   logic [7:0] rxf_rd_data;
   logic       rxf_rd_ready;
   logic       txf_wr_valid;
   logic       txf_wr_ready;
   logic       txf_rd_valid;
   logic [7:0] txf_rd_data;
   logic       txf_rd_ready;
   logic       flush;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic       access;
   logic       done;
   logic       wr_alias;
   logic       rd_alias;
   logic       rd_stat;
   logic       wr_ctrl;
   logic       rx_valid;
   logic [7:0] rx_char;
   logic       rx_ready_now;
   logic       tx_empty_now;
   logic       tx_take;
   logic       tx_src_valid;
   logic [7:0] tx_src_char;

   assign access   = i_psel && i_penable;
   assign o_pready = access && (st.phase == USDP_APB_ANSWER);
   assign done     = o_pready;
   assign wr_alias = done && i_pwrite && usdp_is_alias(i_paddr);
   assign rd_alias = done && !i_pwrite && usdp_is_alias(i_paddr) && st.rd_had;
   assign rd_stat  = done && !i_pwrite && (i_paddr == USDP_STAT_ADDR);
   assign wr_ctrl  = done && i_pwrite && (i_paddr == USDP_CTRL_ADDR);
   assign o_pslverr = done && !usdp_is_mapped(i_paddr);
   assign o_prdata  = st.rdata;

   // switching fifo mode empties both paths, as software expects
   assign flush = wr_ctrl && (i_pwdata[USDP_CTRL_FIFO_EN] != st.fifo_en);

   // ---------------------------------------------------------------
   // receive side
   // ---------------------------------------------------------------
   // the selected deserialiser alone feeds the buffer
   assign rx_valid = st.ir_mode ? i_rx_ir_valid : i_rx_uart_valid;
   assign rx_char  = st.ir_mode ? i_rx_ir_char : i_rx_uart_char;

   assign rxf_wr_valid = st.fifo_en && rx_valid;
   assign rxf_rd_ready = st.fifo_en && rd_alias;
   assign rx_ready_now = st.fifo_en ? rxf_rd_valid : st.rx_full;

   // ---------------------------------------------------------------
   // transmit side
   // ---------------------------------------------------------------
   // a write to a full fifo is simply not pushed
   assign txf_wr_valid = st.fifo_en && wr_alias;
   assign tx_empty_now = st.fifo_en ? !txf_rd_valid : !st.tx_full;
   assign tx_src_valid = st.fifo_en ? txf_rd_valid : st.tx_full;
   assign tx_src_char  = st.fifo_en ? txf_rd_data : st.tx_holding;
   // output stage is one register deep so the char leaves from a flop
   assign tx_take      = tx_src_valid && (!st.tx_valid || i_tx_ready);
   assign txf_rd_ready = st.fifo_en && tx_take;

   // routed by mode; the infrared copy is active low
   assign o_tx_uart_valid = st.tx_valid && !st.ir_mode;
   assign o_tx_ir_valid   = st.tx_valid && st.ir_mode;
   assign o_tx_char       = st.tx_char;
   assign o_tx_ir_char_n  = ~st.tx_char;

   // flags
   assign o_rx_data_ready    = rx_ready_now;
   assign o_tx_holding_empty = tx_empty_now;
   assign o_overrun          = st.overrun;
   assign o_fifo_enable      = st.fifo_en;
   assign o_ir_mode          = st.ir_mode;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      // apb phase: capture read data, then answer one cycle later
      case (st.phase)
         USDP_APB_CAPTURE: begin
            if (access) begin
               next_st.phase  = USDP_APB_ANSWER;
               next_st.rdata  = USDP_WORD_RST;
               next_st.rd_had = 1'b0;
               if (!i_pwrite && usdp_is_alias(i_paddr)) begin
                  next_st.rd_had = rx_ready_now;
                  if (st.fifo_en) begin
                     next_st.rdata[7:0] = rxf_rd_data;
                  end else begin
                     next_st.rdata[7:0] = st.rx_buffer;
                  end
               end else if (!i_pwrite && i_paddr == USDP_CTRL_ADDR) begin
                  next_st.rdata[USDP_CTRL_FIFO_EN] = st.fifo_en;
                  next_st.rdata[USDP_CTRL_IR_MODE] = st.ir_mode;
               end else if (!i_pwrite && i_paddr == USDP_STAT_ADDR) begin
                  next_st.rdata[USDP_STAT_RX_RDY]   = rx_ready_now;
                  next_st.rdata[USDP_STAT_OVERRUN]  = st.overrun;
                  next_st.rdata[USDP_STAT_TX_EMPTY] = tx_empty_now;
                  next_st.rdata[USDP_STAT_TX_FULL]  = st.fifo_en && !txf_wr_ready;
               end
            end
         end
         USDP_APB_ANSWER: begin
            next_st.phase = USDP_APB_CAPTURE;
         end
         default: begin
            next_st.phase = USDP_APB_CAPTURE;
         end
      endcase

      // control register write
      if (wr_ctrl) begin
         next_st.fifo_en = i_pwdata[USDP_CTRL_FIFO_EN];
         next_st.ir_mode = i_pwdata[USDP_CTRL_IR_MODE];
      end

      // receive buffer without fifo: a read frees it unless a char lands now
      if (!st.fifo_en && rd_alias) begin
         next_st.rx_full = 1'b0;
      end
      if (!st.fifo_en && rx_valid) begin
         next_st.rx_buffer = rx_char;
         next_st.rx_full   = 1'b1;
      end

      // overrun clears on a status read, but a new overrun wins
      if (rd_stat) begin
         next_st.overrun = 1'b0;
      end
      if (!st.fifo_en && rx_valid && st.rx_full && !rd_alias) begin
         next_st.overrun = 1'b1;
      end
      if (st.fifo_en && rx_valid && !rxf_wr_ready) begin
         next_st.overrun = 1'b1;
      end

      // holding register without fifo: drain first so a write wins
      if (!st.fifo_en && tx_take) begin
         next_st.tx_full = 1'b0;
      end
      if (!st.fifo_en && wr_alias) begin
         next_st.tx_holding = i_pwdata[7:0];
         next_st.tx_full    = 1'b1;
      end

      // output stage
      if (st.tx_valid && i_tx_ready) begin
         next_st.tx_valid = 1'b0;
      end
      if (tx_take) begin
         next_st.tx_valid = 1'b1;
         next_st.tx_char  = tx_src_char;
      end

      // fifo mode change drops every pending character
      if (flush) begin
         next_st.rx_full  = 1'b0;
         next_st.tx_full  = 1'b0;
         next_st.tx_valid = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st            <= '0;
         st.phase      <= USDP_APB_CAPTURE;
         st.fifo_en    <= USDP_FIFO_EN_RST;
         st.ir_mode    <= USDP_IR_MODE_RST;
         st.rx_buffer  <= USDP_CHAR_RST;
         st.tx_holding <= USDP_CHAR_RST;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // fifos
   // ---------------------------------------------------------------
   // receive fifo: a full fifo keeps its contents
   usdp_fifo #(
      .W (USDP_CHAR_W),
      .D (USDP_FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk_sys  (i_clk_sys),
      .i_sys_rst  (i_sys_rst),
      .i_flush    (flush),
      .i_wr_valid (rxf_wr_valid),
      .i_wr_data  (rx_char),
      .o_wr_ready (rxf_wr_ready),
      .o_rd_valid (rxf_rd_valid),
      .o_rd_data  (rxf_rd_data),
      .i_rd_ready (rxf_rd_ready)
   );

   // transmit fifo: sixteen deep, back-pressure from the serialiser
   usdp_fifo #(
      .W (USDP_CHAR_W),
      .D (USDP_FIFO_DEPTH)
   ) u_tx_fifo (
      .i_clk_sys  (i_clk_sys),
      .i_sys_rst  (i_sys_rst),
      .i_flush    (flush),
      .i_wr_valid (txf_wr_valid),
      .i_wr_data  (i_pwdata[7:0]),
      .o_wr_ready (txf_wr_ready),
      .o_rd_valid (txf_rd_valid),
      .o_rd_data  (txf_rd_data),
      .i_rd_ready (txf_rd_ready)
   );
endmodule : usdp_data_port

/* hdl/usdp_fifo.sv */
// usdp_fifo: parameterised first-word-fall-through fifo, head in a register
`timescale 1ns/1ps
module usdp_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_sys_rst,
   input  wire logic         i_flush,
   // write side
   input  wire logic         i_wr_valid,
   input  wire logic [W-1:0] i_wr_data,
   output logic              o_wr_ready,
   // read side
   output logic              o_rd_valid,
   output logic [W-1:0]      o_rd_data,
   input  wire logic         i_rd_ready
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
      logic [W-1:0]        head;
   } usdp_fifo_state_t;

   usdp_fifo_state_t st;
   usdp_fifo_state_t next_st;
   logic             push;
   logic             pop;

   // handshakes come straight from the count
   assign o_wr_ready = (st.cnt != FULL_CNT);
   assign o_rd_valid = (st.cnt != '0);
   assign o_rd_data  = st.head;
   assign push       = i_wr_valid && o_wr_ready;
   assign pop        = i_rd_ready && o_rd_valid;

   // head register always mirrors the oldest entry
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = i_wr_data;
         next_st.wr         = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      if (pop && st.cnt > 1) begin
         next_st.head = st.mem[st.rd + 1'b1];
      end else if (push && (st.cnt == '0 || (pop && st.cnt == 1))) begin
         next_st.head = i_wr_data;
      end
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (i_flush) begin
         next_st.wr  = '0;
         next_st.rd  = '0;
         next_st.cnt = '0;
      end
   end

   // reset clears the contents and head as well as the pointers
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : usdp_fifo

/* hdl/usdp_pkg.sv */
// usdp_pkg: constants shared by the shadow data port and its fifo
package usdp_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses on the apb bus)
   // ---------------------------------------------------------------
   localparam logic [31:0] USDP_ALIAS_BASE  = 32'h50001030; // alias 0
   localparam logic [31:0] USDP_ALIAS_8     = 32'h50001050;
   localparam logic [31:0] USDP_ALIAS_9     = 32'h50001054;
   localparam logic [31:0] USDP_ALIAS_LAST  = 32'h5000106C; // alias 15
   localparam logic [31:0] USDP_CTRL_ADDR   = 32'h50001070;
   localparam logic [31:0] USDP_STAT_ADDR   = 32'h50001074;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int USDP_CTRL_FIFO_EN = 0;
   localparam int USDP_CTRL_IR_MODE = 1;
   localparam int USDP_STAT_RX_RDY  = 0;
   localparam int USDP_STAT_OVERRUN = 1;
   localparam int USDP_STAT_TX_EMPTY = 5;
   localparam int USDP_STAT_TX_FULL = 6;

   // ---------------------------------------------------------------
   // sizes and reset values
   // ---------------------------------------------------------------
   localparam int         USDP_CHAR_W     = 8;
   localparam int         USDP_FIFO_DEPTH = 16;
   localparam logic [7:0] USDP_CHAR_RST   = 8'h00;
   localparam logic [31:0] USDP_WORD_RST  = 32'h00000000;
   localparam logic       USDP_FIFO_EN_RST = 1'b0;
   localparam logic       USDP_IR_MODE_RST = 1'b0;

   // apb access phase: one wait cycle, then the answer
   typedef enum logic [1:0] {
      USDP_APB_CAPTURE = 2'b01,
      USDP_APB_ANSWER  = 2'b10
   } usdp_apb_phase_t;
endpackage : usdp_pkg

/* test/tb_top.sv */
// tb_top: self-checking bench for the shadow data port
`timescale 1ns/1ps
module tb_top;
   import usdp_pkg::*;
   // -------------------------------------------
   // signals
   // -------------------------------------------
   logic        i_clk_sys = 1'b0;
   logic        i_sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic        stall = 1'b0;
   logic [31:0] padr = 32'h0;
   logic [31:0] pwd = 32'h0;
   logic [31:0] rdq, seed = 32'd7597;
   logic        erq, rdy, err, uv, iv, tu, ti, tr, hre, ovr, fe, irm, drdy;
   logic [31:0] prd;
   logic [7:0]  rc, tc, tcn, c, c2;
   logic [7:0]  arr[18];
   int          n_mismatch = 0;
   int          cmp_count = 0;
   always #4 i_clk_sys = ~i_clk_sys;

   usdp_data_port uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_pready(rdy),
      .o_prdata(prd), .o_pslverr(err), .i_rx_uart_valid(uv), .i_rx_uart_char(rc),
      .i_rx_ir_valid(iv), .i_rx_ir_char(rc), .o_tx_uart_valid(tu), .o_tx_ir_valid(ti),
      .o_tx_char(tc), .o_tx_ir_char_n(tcn), .i_tx_ready(tr), .o_rx_data_ready(drdy),
      .o_tx_holding_empty(hre), .o_overrun(ovr), .o_fifo_enable(fe), .o_ir_mode(irm));
   usdp_line_model line (.i_clk_sys(i_clk_sys), .i_stall(stall), .i_uart_valid(tu),
      .i_ir_valid(ti), .i_char(tc), .i_ir_char_n(tcn), .o_ready(tr), .o_uart_valid(uv),
      .o_ir_valid(iv), .o_char(rc));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // random alias, so every one of the sixteen reaches the data path
   function automatic logic [31:0] ad();
      logic [31:0] w;
      w = xs();
      return USDP_ALIAS_BASE + {26'h0, w[3:0], 2'b00};
   endfunction : ad
   function automatic logic [31:0] st(input logic r, o, e, f);
      st = 32'h0;
      st[USDP_STAT_RX_RDY]   = r;
      st[USDP_STAT_OVERRUN]  = o;
      st[USDP_STAT_TX_EMPTY] = e;
      st[USDP_STAT_TX_FULL]  = f;
   endfunction : st
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // one apb transfer; pready and read data are taken at the completing rising edge
   task automatic apb(input logic wr, input logic [31:0] a, d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      psel <= 1'b1;
      pwr  <= wr;
      padr <= a;
      pwd  <= d;
      @(posedge i_clk_sys);
      pen <= 1'b1;
      // request stays put until pready is seen high at a rising edge
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
      rdq = prd;
      erq = err;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic wait_got(input int n);
      int k;
      k = 0;
      while (line.got_q.size() < n && k < 800) begin
         @(posedge i_clk_sys);
         k++;
      end
      if (k >= 800) begin
         n_mismatch++;
         conclude();
      end
   endtask : wait_got

   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      apb(0, USDP_STAT_ADDR, 0); chk("stat_rst", rdq, st(0, 0, 1, 0));
      apb(0, 32'h50001078, 0); chk("slverr", {31'h0, erq}, 1);
      for (int m = 0; m < 2; m++) begin
         apb(1, USDP_CTRL_ADDR, m << USDP_CTRL_IR_MODE);
         // control bits are registered, so look one edge after the write
         @(posedge i_clk_sys);
         chk("mode_pins", {30'h0, fe, irm}, m);
         c = 8'(xs());
         line.send(c, m[0]);
         apb(0, ad(), 0); chk("rx_char", rdq, {24'h0, c});
         line.send(c + 8'h1, m[0]);
         line.send(c + 8'h2, m[0]);
         @(posedge i_clk_sys);
         chk("ovr_pins", {30'h0, ovr, drdy}, 3);
         apb(0, USDP_STAT_ADDR, 0); chk("overrun", rdq, st(1, 1, 1, 0));
         apb(0, ad(), 0); chk("rx_last", rdq, {24'h0, c + 8'h2});
         // stalled line: first char parks in output stage, then overwrites
         stall <= 1'b1;
         apb(1, ad(), {xs() & 32'hFFFFFF00} | c);
         apb(1, ad(), 32'hA5);
         // holding empty moves at the completing edge; sample once it settles
         @(posedge i_clk_sys);
         chk("tx_holding_empty", {31'h0, hre}, 0);
         c2 = 8'(xs());
         apb(1, ad(), {24'hFFFFFF, c2});
         stall <= 1'b0;
         wait_got(2);
         chk("tx_first", line.got_q[0], c);
         chk("tx_over", line.got_q[1], c2);
         line.got_q.delete();
      end
      apb(1, USDP_CTRL_ADDR, 1);
      stall <= 1'b1;
      for (int i = 0; i < 18; i++) begin
         arr[i] = 8'(xs());
         apb(1, ad(), {24'h0, arr[i]});
      end
      apb(0, USDP_STAT_ADDR, 0); chk("tx_full", rdq, st(0, 0, 0, 1));
      stall <= 1'b0;
      wait_got(17);
      repeat (20) @(posedge i_clk_sys);
      chk("tx_cnt", line.got_q.size(), 17);
      for (int i = 0; i < 17; i++) chk("tx_fifo", line.got_q[i], arr[i]);
      for (int i = 0; i < 17; i++) line.send(arr[i] ^ 8'h3C, 1'b0);
      apb(0, USDP_STAT_ADDR, 0); chk("rx_ovr", rdq, st(1, 1, 1, 0));
      for (int i = 0; i < 16; i++) begin
         apb(0, ad(), 0); chk("rx_fifo", rdq, {24'h0, arr[i] ^ 8'h3C});
      end
      apb(0, USDP_STAT_ADDR, 0); chk("rx_empty", rdq, st(0, 0, 1, 0));
      conclude();
   end
endmodule : tb_top

/* test/usdp_asserts.sv */
// usdp_asserts: port-level checks of the shadow data port
`timescale 1ns/1ps
module usdp_asserts
   import usdp_pkg::*;
(
   // clock, reset and apb
   input wire logic        i_clk_sys,
   input wire logic        i_sys_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [31:0] i_paddr,
   input wire logic        o_pready,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pslverr,
   // line side and flags
   input wire logic        i_rx_uart_valid,
   input wire logic        i_rx_ir_valid,
   input wire logic        o_tx_uart_valid,
   input wire logic        o_tx_ir_valid,
   input wire logic [7:0]  o_tx_char,
   input wire logic [7:0]  o_tx_ir_char_n,
   input wire logic        i_tx_ready,
   input wire logic        o_rx_data_ready,
   input wire logic        o_tx_holding_empty,
   input wire logic        o_overrun,
   input wire logic        o_fifo_enable,
   input wire logic        o_ir_mode
);
   // -------------------------------------------
   // decode helpers
   // -------------------------------------------
   logic hit;
   logic done;
   logic ctl_wr;
   logic rx_sel;
   logic rd_hit;
   assign hit    = i_paddr >= USDP_ALIAS_BASE && i_paddr <= USDP_ALIAS_LAST
                   && i_paddr[1:0] == 2'h0;
   assign done   = i_psel && i_penable && o_pready;
   // a control write that changes fifo mode flushes both paths, so any control write masks the tx hold, overrun and data ready checks
   assign ctl_wr = done && i_pwrite && i_paddr == USDP_CTRL_ADDR;
   assign rx_sel = o_ir_mode ? i_rx_ir_valid : i_rx_uart_valid;
   assign rd_hit = done && !i_pwrite && hit;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   property p_one_wait;
      $rose(i_penable) && i_psel |-> !o_pready ##1 o_pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready timing wrong");
   property p_decode;
      o_pready |-> o_pslverr == !(hit || i_paddr == USDP_CTRL_ADDR
                                  || i_paddr == USDP_STAT_ADDR);
   endproperty
   a_decode: assert property (p_decode) else $error("alias decode wrong");
   property p_upper_zero;
      rd_hit |-> o_prdata[31:8] == 24'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   property p_ir_inv;
      o_tx_ir_char_n == ~o_tx_char;
   endproperty
   a_ir_inv: assert property (p_ir_inv) else $error("infrared copy not inverted");
   property p_valid_mode;
      !(o_tx_ir_valid && !o_ir_mode) && !(o_tx_uart_valid && o_ir_mode);
   endproperty
   a_valid_mode: assert property (p_valid_mode) else $error("tx valid on wrong line");
   property p_tx_hold;
      o_tx_uart_valid && !i_tx_ready && !ctl_wr |=> o_tx_uart_valid && $stable(o_tx_char);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx char dropped");
   property p_tx_holding_empty_clear;
      done && i_pwrite && hit && !o_fifo_enable && o_tx_holding_empty
         |=> !o_tx_holding_empty;
   endproperty
   a_tx_holding_empty_clear: assert property (p_tx_holding_empty_clear) else $error("holding empty stuck");
   property p_overrun;
      !o_fifo_enable && o_rx_data_ready && rx_sel && !ctl_wr && !rd_hit |=> o_overrun;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");
   property p_rx_ready;
      rx_sel && !ctl_wr |=> o_rx_data_ready;
   endproperty
   a_rx_ready: assert property (p_rx_ready) else $error("data ready missed");
endmodule : usdp_asserts

bind usdp_data_port usdp_asserts u_chk (.*);

/* test/usdp_line_model.sv */
// usdp_line_model: serialiser and deserialiser side of the data port
`timescale 1ns/1ps
module usdp_line_model (
   // clock and stall control
   input  wire logic       i_clk_sys,
   input  wire logic       i_stall,
   // characters from the port
   input  wire logic       i_uart_valid,
   input  wire logic       i_ir_valid,
   input  wire logic [7:0] i_char,
   input  wire logic [7:0] i_ir_char_n,
   output logic            o_ready,
   // characters to the port
   output logic            o_uart_valid,
   output logic            o_ir_valid,
   output logic [7:0]      o_char
);
   logic [7:0] got_q[$];
   logic [7:0] lf = 8'hA5;
   initial begin
      o_ready      = 1'b0;
      o_uart_valid = 1'b0;
      o_ir_valid   = 1'b0;
      o_char       = 8'h5A;
   end
   // random ready so the port sees both prompt and slow takers
   always @(posedge i_clk_sys) begin
      lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      o_ready <= !i_stall && lf[0];
      if (o_ready && i_ir_valid) got_q.push_back(~i_ir_char_n);
      else if (o_ready && i_uart_valid) got_q.push_back(i_char);
   end
   // one-cycle pulse, then the char line shows junk
   task automatic send(input logic [7:0] c, input logic ir);
      @(posedge i_clk_sys);
      o_char       <= c;
      o_uart_valid <= !ir;
      o_ir_valid   <= ir;
      @(posedge i_clk_sys);
      o_uart_valid <= 1'b0;
      o_ir_valid   <= 1'b0;
      o_char       <= ~c;
   endtask : send
endmodule : usdp_line_model
